/* File: ifr_chip_signal.sv */
// Chip signal status bits that software sets and clears, each driving one
// chip-level interrupt line. Assumes write strobes are one cycle long.
`default_nettype none

module ifr_chip_signal
  import ifr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [NUM_CHIP-1:0] wdata,
  output logic [NUM_CHIP-1:0] status
);

  logic [NUM_CHIP-1:0] next_status;

  // ==========================================================================
  // Write one to set, write one to the clear port to drop the line
  assign next_status = set_we ? (status | wdata) : clr_we ? (status & ~wdata) : status;

  // Status bit is the line itself, held for as long as the bit stays set
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

endmodule : ifr_chip_signal

`default_nettype wire

/* File: ifr_edge_detect.sv */
// Synchronises external interrupt pins and finds their rising edges.
// Assumes the pins are asynchronous to CLOCK; outputs are in the CLOCK domain.
`default_nettype none

module ifr_edge_detect
  import ifr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [NUM_EXT-1:0] pin_in,
  output logic [NUM_EXT-1:0] level,
  output logic [NUM_EXT-1:0] rise
);

  // ==========================================================================
  // Per-pin two-stage synchroniser and edge finder
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_pin
      logic meta;
      logic sync;
      logic prev;
      // First stage feeds only the second stage
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          meta <= 1'b0;
          sync <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= pin_in[g];
          sync <= meta;
          prev <= sync;
        end
      end
      // One pulse per rising transition
      assign rise[g] = sync & ~prev;
      assign level[g] = sync;
    end
  endgenerate

endmodule : ifr_edge_detect

`default_nettype wire

/* File: ifr_pkg.sv */
// Constants, register map and carrier types for the interrupt flag router.
// Assumes a single clock domain and a simple strobe-driven register port.
`default_nettype none

package ifr_pkg;

  // ==========================================================================
  // Source counts
  localparam int NUM_EXT = 12;
  localparam int NUM_CHIP = 4;
  localparam int NUM_SRC = NUM_EXT + NUM_CHIP;
  localparam int IDX_W = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG_STATUS = 8'h00;
  localparam logic [7:0] OFS_FLAG_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FAST_SELECT = 8'h08;
  localparam logic [7:0] OFS_VECTOR_BASE = 8'h0C;
  localparam logic [7:0] OFS_VECTOR_SIZE = 8'h10;
  localparam logic [7:0] OFS_VECTOR_ADDR = 8'h14;
  localparam logic [7:0] OFS_ACTIVE = 8'h18;
  localparam logic [7:0] OFS_SIG_STATUS = 8'h1C;
  localparam logic [7:0] OFS_SIG_CLEAR = 8'h20;
  localparam logic [7:0] OFS_RAW_LEVEL = 8'h24;

  // ==========================================================================
  // Vector size field: spacing in bytes is one shifted left by the code
  localparam int VSZ_W = 2;
  localparam logic [VSZ_W-1:0] VSZ_RESET = 2'h0;       // Comes up at 1 byte
  localparam logic [VSZ_W-1:0] VSZ_DOC_DEFAULT = 2'h2; // Intended 4 bytes

  // ==========================================================================
  // Reset values and field positions
  localparam logic [31:0] VECTOR_BASE_RESET = 32'h0000_0000;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [NUM_SRC-1:0] FAST_SELECT_RESET = 16'h0000;
  localparam int ACTIVE_VALID_BIT = 31;
  localparam int ACTIVE_FAST_BIT = 30;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // ==========================================================================
  // Register port request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ifr_req_t;

endpackage : ifr_pkg

`default_nettype wire

/* File: ifr_props.sv */
// Port-level checks for the interrupt flag router.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module ifr_props
  import ifr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire ifr_req_t REQ,
  input wire logic [31:0] RDATA,
  input wire logic [NUM_EXT-1:0] SRC_IN,
  input wire logic [NUM_CHIP-1:0] CHIP_INT,
  input wire logic FAST_REQ,
  input wire logic NORMAL_REQ,
  input wire logic [31:0] VECTOR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // ==========================================================================
  // Writes that set or clear chip signal bit zero
  wire sig_set = REQ.wr && REQ.addr == OFS_SIG_STATUS && REQ.wdata[0];
  wire sig_clr = REQ.wr && REQ.addr == OFS_SIG_CLEAR && REQ.wdata[0];
  sequence s_line_up;
    ##[1:3] CHIP_INT[0];
  endsequence
  sequence s_line_down;
    ##[1:3] !CHIP_INT[0];
  endsequence

  // ==========================================================================
  // Assertions
  a_rdata_idle: assert property (!REQ.rd |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_chip_set: assert property (sig_set |-> s_line_up)
    else $error("chip line did not rise");
  a_chip_level: assert property (CHIP_INT[0] && !sig_clr && !$past(sig_clr) |=> CHIP_INT[0])
    else $error("chip line dropped on its own");
  a_chip_drop: assert property (sig_clr |-> s_line_down)
    else $error("chip line still high after clear");
  a_chip_cause: assert property ($changed(CHIP_INT) && $past(RESET_N) |-> $past(REQ.wr) || $past(REQ.wr, 2))
    else $error("chip line moved without a write");
  a_reset_quiet: assert property ($rose(RESET_N) |-> !FAST_REQ && !NORMAL_REQ && VECTOR == 32'h0 && CHIP_INT == 4'h0)
    else $error("outputs not idle after reset");
  a_normal_sticky: assert property (NORMAL_REQ && !REQ.wr && !$past(REQ.wr) |=> NORMAL_REQ)
    else $error("normal request fell without a write");
  a_fast_sticky: assert property (FAST_REQ && !REQ.wr && !$past(REQ.wr) |=> FAST_REQ)
    else $error("fast request fell without a write");
endmodule : ifr_props

bind ifr_top ifr_props i_ifr_props (.CLOCK, .RESET_N, .REQ, .RDATA, .SRC_IN, .CHIP_INT, .FAST_REQ, .NORMAL_REQ, .VECTOR);

`default_nettype wire

/* File: ifr_src_model.sv */
// Model of the external interrupt sources on the router's pins.
// Assumes its tasks are called just after a rising clock edge.
`default_nettype none

module ifr_src_model
  import ifr_pkg::*;
(
  input wire logic clock,
  output logic [NUM_EXT-1:0] src
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low
  initial src = '0;

  // Raise one pin for some cycles, then drop it
  task automatic pulse(input int idx, input int len);
    src[idx] <= 1'b1;
    repeat (len) @(posedge clock);
    src[idx] <= 1'b0;
  endtask : pulse
endmodule : ifr_src_model

`default_nettype wire

/* File: ifr_top.sv */
// Interrupt flag router: holds one flag per source and routes enabled flags
// to a fast and a normal request, with a priority vector for the winner.
// Assumes one clock, a synchronous active-low reset and a strobed register port.
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none

module ifr_top
  import ifr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire ifr_req_t REQ,
  output logic [31:0] RDATA,
  input wire logic [NUM_EXT-1:0] SRC_IN,
  output logic [NUM_CHIP-1:0] CHIP_INT,
  output logic FAST_REQ,
  output logic NORMAL_REQ,
  output logic [31:0] VECTOR
);

  // ==========================================================================
  // Declarations
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] fast_select;
  logic [31:0] vector_base;
  logic [VSZ_W-1:0] vector_size_register;
  logic [NUM_SRC-1:0] next_flags;
  logic [NUM_SRC-1:0] set_events;
  logic [NUM_SRC-1:0] clr_mask;
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_EXT-1:0] ext_rise;
  logic [NUM_CHIP-1:0] chip_level_interrupt_n;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] fast_pend;
  logic [NUM_SRC-1:0] norm_pend;
  logic any_fast;
  logic any_norm;
  logic any_pend;
  logic [IDX_W-1:0] fast_idx;
  logic [IDX_W-1:0] norm_idx;
  logic [IDX_W-1:0] act_idx;
  logic [31:0] vec_offset;
  logic [31:0] next_vector;
  logic [31:0] active_word;
  logic [31:0] read_word;
  logic [31:0] next_rdata;

  // ==========================================================================
  // Priority encoder: lowest numbered set bit wins
  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  // ==========================================================================
  // Address decode
  wire wr_flag_status = REQ.wr && (REQ.addr == OFS_FLAG_STATUS);
  wire wr_flag_enable = REQ.wr && (REQ.addr == OFS_FLAG_ENABLE);
  wire wr_fast_select = REQ.wr && (REQ.addr == OFS_FAST_SELECT);
  wire wr_vector_base = REQ.wr && (REQ.addr == OFS_VECTOR_BASE);
  wire wr_vector_size = REQ.wr && (REQ.addr == OFS_VECTOR_SIZE);
  wire wr_sig_status = REQ.wr && (REQ.addr == OFS_SIG_STATUS);
  wire wr_sig_clear = REQ.wr && (REQ.addr == OFS_SIG_CLEAR);

  // ==========================================================================
  // External pins: synchronised, one event per rising edge
  ifr_edge_detect u_edge (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .pin_in(SRC_IN),
    .level(ext_level),
    .rise(ext_rise)
  );

  // ==========================================================================
  // Chip signal status bits and their chip-level lines
  ifr_chip_signal u_chip (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .set_we(wr_sig_status),
    .clr_we(wr_sig_clear),
    .wdata(REQ.wdata[NUM_CHIP-1:0]),
    .status(chip_level_interrupt_n)
  );

  // ==========================================================================
  // Event detection
  // External sources give one pulse per rising edge. Chip-level lines are
  // levels but detection expects pulses, so every cycle a line stays high
  // counts as a fresh pulse and re-arms a flag that software just cleared.
  assign set_events = {chip_level_interrupt_n, ext_rise};

  // Write-one-to-clear mask from software
  assign clr_mask = wr_flag_status ? REQ.wdata[NUM_SRC-1:0] : '0;

  // Single flag per source; a new event in the clearing cycle wins
  assign next_flags = (flags & ~clr_mask) | set_events;

  // Flag register
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      enable <= ENABLE_RESET;
      fast_select <= FAST_SELECT_RESET;
      vector_base <= VECTOR_BASE_RESET;
    end else begin
      if (wr_flag_enable) begin
        enable <= REQ.wdata[NUM_SRC-1:0];
      end
      if (wr_fast_select) begin
        fast_select <= REQ.wdata[NUM_SRC-1:0];
      end
      if (wr_vector_base) begin
        vector_base <= REQ.wdata;
      end
    end
  end

  // Vector size comes up at the 1-byte code rather than the 4-byte default
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      vector_size_register <= VSZ_RESET;
    end else if (wr_vector_size) begin
      vector_size_register <= REQ.wdata[VSZ_W-1:0];
    end
  end

  // ==========================================================================
  // Routing onto the two processor requests
  assign pending = flags & enable;
  assign fast_pend = pending & fast_select;
  assign norm_pend = pending & ~fast_select;
  assign any_fast = |fast_pend;
  assign any_norm = |norm_pend;
  assign any_pend = any_fast | any_norm;

  // Winner: fast sources first, then the lowest numbered source
  assign fast_idx = first_set(fast_pend);
  assign norm_idx = first_set(norm_pend);
  assign act_idx = any_fast ? fast_idx : norm_idx;

  // Entry spacing is one byte shifted by the vector size code
  assign vec_offset = {{(32 - IDX_W){1'b0}}, act_idx} << vector_size_register;
  assign next_vector = any_pend ? (vector_base + vec_offset) : vector_base;

  // Active word: valid, fast flag and winning index
  assign active_word = {any_pend, any_fast, {(30 - IDX_W){1'b0}}, act_idx};

  // Requests and vector, registered so outputs come from flip-flops
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      FAST_REQ <= 1'b0;
      NORMAL_REQ <= 1'b0;
      VECTOR <= VECTOR_BASE_RESET;
    end else begin
      FAST_REQ <= any_fast;
      NORMAL_REQ <= any_norm;
      VECTOR <= next_vector;
    end
  end

  // Chip-level lines are observable at the pins
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CHIP_INT <= '0;
    end else begin
      CHIP_INT <= chip_level_interrupt_n;
    end
  end

  // ==========================================================================
  // Read mux: unmapped offsets read zero
  assign read_word =
    (REQ.addr == OFS_FLAG_STATUS) ? {{(32 - NUM_SRC){1'b0}}, flags} :
    (REQ.addr == OFS_FLAG_ENABLE) ? {{(32 - NUM_SRC){1'b0}}, enable} :
    (REQ.addr == OFS_FAST_SELECT) ? {{(32 - NUM_SRC){1'b0}}, fast_select} :
    (REQ.addr == OFS_VECTOR_BASE) ? vector_base :
    (REQ.addr == OFS_VECTOR_SIZE) ? {{(32 - VSZ_W){1'b0}}, vector_size_register} :
    (REQ.addr == OFS_VECTOR_ADDR) ? next_vector :
    (REQ.addr == OFS_ACTIVE) ? active_word :
    (REQ.addr == OFS_SIG_STATUS) ? {{(32 - NUM_CHIP){1'b0}}, chip_level_interrupt_n} :
    (REQ.addr == OFS_SIG_CLEAR) ? {{(32 - NUM_CHIP){1'b0}}, chip_level_interrupt_n} :
    (REQ.addr == OFS_RAW_LEVEL) ? {{(32 - NUM_EXT){1'b0}}, ext_level} :
    READ_IDLE;

  // Read data stand only in the cycle after the read strobe
  assign next_rdata = REQ.rd ? read_word : READ_IDLE;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      RDATA <= READ_IDLE;
    end else begin
      RDATA <= next_rdata;
    end
  end

endmodule : ifr_top

`default_nettype wire

/* File: tb_ifr_top.sv */
// Self-checking bench for the interrupt flag router.
// Assumes the source model and checker files are compiled first.
`default_nettype none

module tb_ifr_top
  import ifr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK;
  logic RESET_N;
  ifr_req_t REQ;
  logic [31:0] RDATA;
  logic [NUM_EXT-1:0] SRC_IN;
  logic [NUM_CHIP-1:0] CHIP_INT;
  logic FAST_REQ;
  logic NORMAL_REQ;
  logic [31:0] VECTOR;
  int n_mismatch;
  int comparisons;
  wire [31:0] reqs = {30'h0, FAST_REQ, NORMAL_REQ};

  ifr_top i_ifr_top (.CLOCK, .RESET_N, .REQ, .RDATA, .SRC_IN, .CHIP_INT, .FAST_REQ, .NORMAL_REQ, .VECTOR);
  ifr_src_model i_ifr_src_model (.clock(CLOCK), .src(SRC_IN));

  // Clock at 125 MHz
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLOCK);
    REQ.wr <= 1'b0;
    @(posedge CLOCK);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    REQ <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge CLOCK);
    REQ.rd <= 1'b0;
    #1 chk(RDATA, exp);
    @(posedge CLOCK);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : idle

  task automatic test_done;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial begin
    idle(5000);
    $display("Error at %0t: timeout", $time);
    n_mismatch++;
    test_done;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    REQ = '0;
    RESET_N = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    idle(16);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    rd(OFS_VECTOR_SIZE, 32'h0);
    rd(OFS_FLAG_ENABLE, 32'h0);
    rd(8'h3C, 32'h0);
    wr(OFS_VECTOR_BASE, 32'h100);
    wr(OFS_FLAG_ENABLE, 32'h1028);
    wr(OFS_FAST_SELECT, 32'h20);
    // Spacing of one byte until the size is written
    i_ifr_src_model.pulse(3, 2);
    idle(6);
    #1 chk(VECTOR, 32'h103);
    chk(reqs, 32'h1);
    wr(OFS_VECTOR_SIZE, {30'h0, VSZ_DOC_DEFAULT});
    idle(2);
    #1 chk(VECTOR, 32'h10C);
    // Repeated pulses on a freshly cleared source leave one flag
    wr(OFS_FLAG_STATUS, 32'h8);
    for (int i = 0; i < 3; i++) begin
      i_ifr_src_model.pulse(3, 2);
      idle(3);
    end
    rd(OFS_FLAG_STATUS, 32'h8);
    wr(OFS_FLAG_STATUS, 32'h8);
    idle(2);
    rd(OFS_FLAG_STATUS, 32'h0);
    #1 chk(reqs, 32'h0);
    // Fast route with priority vector
    i_ifr_src_model.pulse(5, 2);
    idle(6);
    rd(OFS_ACTIVE, 32'hC000_0005);
    #1 chk(reqs, 32'h2);
    chk(VECTOR, 32'h114);
    wr(OFS_FLAG_STATUS, 32'h20);
    // Disabled source flags but does not route
    i_ifr_src_model.pulse(7, 2);
    idle(6);
    rd(OFS_FLAG_STATUS, 32'h80);
    #1 chk(reqs, 32'h0);
    wr(OFS_FLAG_STATUS, 32'h80);
    // Chip line: early clear re-flags, proper order quiets it
    wr(OFS_SIG_STATUS, 32'h1);
    idle(3);
    #1 chk({28'h0, CHIP_INT}, 32'h1);
    chk(reqs, 32'h1);
    rd(OFS_SIG_STATUS, 32'h1);
    wr(OFS_FLAG_STATUS, 32'h1000);
    rd(OFS_FLAG_STATUS, 32'h1000);
    wr(OFS_SIG_CLEAR, 32'h1);
    idle(3);
    wr(OFS_FLAG_STATUS, 32'h1000);
    idle(2);
    rd(OFS_FLAG_STATUS, 32'h0);
    #1 chk({28'h0, CHIP_INT}, 32'h0);
    chk(reqs, 32'h0);
    rd(OFS_SIG_STATUS, 32'h0);
    test_done;
  end
endmodule : tb_ifr_top

`default_nettype wire
